// ==== fskdm_defines.svh ====
`ifndef FSKDM_DEFINES_SVH
`define FSKDM_DEFINES_SVH

// Register byte offsets
`define FSKDM_OFS_MODE 8'h00
`define FSKDM_OFS_TONES 8'h04
`define FSKDM_OFS_SETUP 8'h08
`define FSKDM_OFS_TXCODE 8'h0C
`define FSKDM_OFS_CTRL 8'h10
`define FSKDM_OFS_STATUS 8'h14
`define FSKDM_OFS_MASK 8'h18
`define FSKDM_OFS_THRESH 8'h1C
`define FSKDM_OFS_STATE 8'h20

// Reset values
`define FSKDM_RST_BYTE 8'h00
`define FSKDM_RST_CTRL 1'b1
`define FSKDM_RST_ON_THR 8'h40
`define FSKDM_RST_OFF_THR 8'h30

// Status bit positions
`define FSKDM_ST_REFLOST 0
`define FSKDM_ST_DETECT 4
`define FSKDM_ST_W 8

// Reference clock and clock rates
`define FSKDM_REF_HZ 64'h0000_0000_0036_9E99
`define FSKDM_ACC_ONE 64'h0000_0000_0100_0000
`define FSKDM_CLK_MHZ 10
`define FSKDM_REFLOST_CYC 8'h10

// Phase increment per reference edge for a tone in Hz
`define FSKDM_INC(f) 24'((64'(f) * `FSKDM_ACC_ONE) / `FSKDM_REF_HZ)

// Tone frequencies in Hz
`define FSKDM_F_390 390
`define FSKDM_F_450 450
`define FSKDM_F_1300 1300
`define FSKDM_F_2100 2100
`define FSKDM_F_387 387
`define FSKDM_F_487 487
`define FSKDM_F_1200 1200
`define FSKDM_F_2200 2200
`define FSKDM_F_697 697
`define FSKDM_F_770 770
`define FSKDM_F_852 852
`define FSKDM_F_941 941
`define FSKDM_F_1209 1209
`define FSKDM_F_1336 1336
`define FSKDM_F_1477 1477
`define FSKDM_F_1633 1633

// Modulator output
`define FSKDM_MID 10'h200
`define FSKDM_LIFT 10'h100

// Detector qualification times in microseconds
`define FSKDM_DET_ON_US 25000
`define FSKDM_DET_OFF_US 10000

`endif

// ==== fskdm_nco.sv ====
`timescale 1ns/1ps
module fskdm_nco #(
    parameter int ACC_W = 24
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic step,
    input wire logic [ACC_W-1:0] inc,
    output logic [ACC_W-1:0] phase
);
    // Phase keeps running across increment changes, so tones switch without a jump
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase <= '0;
        end else if (step) begin
            phase <= phase + inc;
        end
    end
endmodule

// ==== fskdm_pkg.sv ====
package fskdm_pkg;

    typedef struct packed {
        logic rx_async;
        logic eq_en;
        logic band_hi;
        logic band_lo;
        logic tx_async;
        logic level_hi;
        logic tx_en;
        logic rate_1200;
    } fskdm_mode_type;

    typedef struct packed {
        logic dtmf;
        logic out_en;
        logic rsv5;
        logic single;
        logic rsv3;
        logic rsv2;
        logic rsv1;
        logic det_2100;
    } fskdm_tones_type;

    typedef struct packed {
        logic [1:0] band;
        logic eq_en;
        logic demod_en;
    } fskdm_rxctl_type;

    typedef enum logic [1:0] {
        FSKDM_IDLE = 2'b00,
        FSKDM_QUAL_ON = 2'b01,
        FSKDM_ACTIVE = 2'b11,
        FSKDM_QUAL_OFF = 2'b10
    } fskdm_det_state_type;

endpackage

// ==== fskdm_ref_model.sv ====
`timescale 1ns/1ps
module fskdm_ref_model #(
    parameter int HALF_NS = 400
) (
    input wire logic run,
    output logic ref_clk
);
    // Outside source: toggles while the device is awake, parked low otherwise
    initial begin
        ref_clk = 1'b0;
        #37;
        forever begin
            #(HALF_NS);
            ref_clk = run ? ~ref_clk : 1'b0;
        end
    end
endmodule

// ==== fskdm_sync.sv ====
`timescale 1ns/1ps
module fskdm_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ==== fskdm_top.sv ====
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "fskdm_defines.svh"
module fskdm_top #(
    parameter int ACC_W = 24,
    parameter int CNT_W = 24,
    parameter int DET_ON_CYCLES = `FSKDM_DET_ON_US * `FSKDM_CLK_MHZ,
    parameter int DET_OFF_CYCLES = `FSKDM_DET_OFF_US * `FSKDM_CLK_MHZ
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_clk,
    input wire logic [7:0] rx_level,
    input wire logic tone_2100_valid,
    input wire logic rx_demod_bit,
    input wire logic tx_bit,
    output logic osc_enable,
    output fskdm_pkg::fskdm_rxctl_type rx_ctl,
    output logic rx_data,
    output logic det_flag,
    output logic [9:0] mod_out,
    output logic tx_filter_connect,
    output logic irq
);
    import fskdm_pkg::*;

    fskdm_mode_type mode;
    fskdm_tones_type tones;
    logic bell;
    logic [3:0] tx_code;
    logic zero_power;
    logic [`FSKDM_ST_W-1:0] status;
    logic [`FSKDM_ST_W-1:0] mask;
    logic [7:0] on_thr;
    logic [7:0] off_thr;
    logic ref_s;
    logic ref_d;
    logic ref_tick;
    logic [7:0] ref_idle;
    logic ref_lost_ev;
    logic det_rise_ev;
    fskdm_det_state_type det_state;
    logic [CNT_W-1:0] det_cnt;
    logic det_in;
    logic [ACC_W-1:0] inc [2];
    logic [ACC_W-1:0] phase [2];
    logic [8:0] tri_w [2];
    logic tx_dual;
    logic tx_on;
    logic [9:0] next_mod;
    logic [31:0] rd_val;
    logic rd_ok;
    logic wr_en;

    localparam logic [CNT_W-1:0] ON_LAST = CNT_W'(DET_ON_CYCLES - 1);
    localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(DET_OFF_CYCLES - 1);

    function automatic logic [ACC_W-1:0] dtmf_low(input logic [3:0] c);
        case (c)
            4'h1, 4'h2, 4'h3, 4'hD: dtmf_low = `FSKDM_INC(`FSKDM_F_697);
            4'h4, 4'h5, 4'h6, 4'hE: dtmf_low = `FSKDM_INC(`FSKDM_F_770);
            4'h7, 4'h8, 4'h9, 4'hF: dtmf_low = `FSKDM_INC(`FSKDM_F_852);
            default: dtmf_low = `FSKDM_INC(`FSKDM_F_941);
        endcase
    endfunction

    function automatic logic [ACC_W-1:0] dtmf_high(input logic [3:0] c);
        case (c)
            4'h1, 4'h4, 4'h7, 4'hB: dtmf_high = `FSKDM_INC(`FSKDM_F_1209);
            4'h2, 4'h5, 4'h8, 4'hA: dtmf_high = `FSKDM_INC(`FSKDM_F_1336);
            4'h3, 4'h6, 4'h9, 4'hC: dtmf_high = `FSKDM_INC(`FSKDM_F_1477);
            default: dtmf_high = `FSKDM_INC(`FSKDM_F_1633);
        endcase
    endfunction

    function automatic logic [ACC_W-1:0] fsk_inc(input logic b, input logic r,
                                                 input logic d);
        if (b) begin
            if (r) begin
                fsk_inc = d ? `FSKDM_INC(`FSKDM_F_1200) : `FSKDM_INC(`FSKDM_F_2200);
            end else begin
                fsk_inc = d ? `FSKDM_INC(`FSKDM_F_387) : `FSKDM_INC(`FSKDM_F_487);
            end
        end else begin
            if (r) begin
                fsk_inc = d ? `FSKDM_INC(`FSKDM_F_1300) : `FSKDM_INC(`FSKDM_F_2100);
            end else begin
                fsk_inc = d ? `FSKDM_INC(`FSKDM_F_390) : `FSKDM_INC(`FSKDM_F_450);
            end
        end
    endfunction

    // APB: no wait states; read data and answer come from flops loaded in the setup cycle
    assign wr_en = psel && penable && pready && pwrite;

    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0000_0000;
        case (paddr)
            `FSKDM_OFS_MODE: rd_val[7:0] = mode;
            `FSKDM_OFS_TONES: rd_val[7:0] = tones;
            `FSKDM_OFS_SETUP: rd_val[7] = bell;
            `FSKDM_OFS_TXCODE: rd_val[3:0] = tx_code;
            `FSKDM_OFS_CTRL: rd_val[0] = zero_power;
            `FSKDM_OFS_STATUS: rd_val[`FSKDM_ST_W-1:0] = status;
            `FSKDM_OFS_MASK: rd_val[`FSKDM_ST_W-1:0] = mask;
            `FSKDM_OFS_THRESH: rd_val[15:0] = {off_thr, on_thr};
            `FSKDM_OFS_STATE: rd_val[4:0] = {ref_s, osc_enable, det_state, det_flag};
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !rd_ok;
            prdata <= (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode <= `FSKDM_RST_BYTE;
            tones <= `FSKDM_RST_BYTE;
            bell <= 1'b0;
            tx_code <= 4'h0;
            zero_power <= `FSKDM_RST_CTRL;
            mask <= `FSKDM_RST_BYTE;
            on_thr <= `FSKDM_RST_ON_THR;
            off_thr <= `FSKDM_RST_OFF_THR;
        end else if (wr_en) begin
            case (paddr)
                `FSKDM_OFS_MODE: mode <= pwdata[7:0];
                `FSKDM_OFS_TONES: tones <= pwdata[7:0];
                `FSKDM_OFS_SETUP: bell <= pwdata[7];
                `FSKDM_OFS_TXCODE: tx_code <= pwdata[3:0];
                `FSKDM_OFS_CTRL: zero_power <= pwdata[0];
                `FSKDM_OFS_MASK: mask <= pwdata[`FSKDM_ST_W-1:0];
                `FSKDM_OFS_THRESH: begin
                    on_thr <= pwdata[7:0];
                    off_thr <= pwdata[15:8];
                end
                default: ;
            endcase
        end
    end

    // Sticky events; a new event wins over a write-one clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status <= `FSKDM_RST_BYTE;
        end else begin
            for (int i = 0; i < `FSKDM_ST_W; i++) begin
                if (wr_en && paddr == `FSKDM_OFS_STATUS && pwdata[i]) begin
                    status[i] <= 1'b0;
                end
            end
            if (ref_lost_ev) begin
                status[`FSKDM_ST_REFLOST] <= 1'b1;
            end
            if (det_rise_ev) begin
                status[`FSKDM_ST_DETECT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_enable <= 1'b0;
        end else begin
            osc_enable <= !zero_power;
        end
    end

    // Reference clock is sampled; its rising edges drive all tone timing
    fskdm_sync u_ref_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async_in(ref_clk),
        .sync_out(ref_s)
    );

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_d <= 1'b0;
        end else begin
            ref_d <= ref_s;
        end
    end

    assign ref_tick = ref_s && !ref_d && !zero_power;

    // A stalled reference while running points to a missing zero-power request
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ref_idle <= 8'h00;
            ref_lost_ev <= 1'b0;
        end else begin
            ref_lost_ev <= 1'b0;
            if (zero_power || (ref_s && !ref_d)) begin
                ref_idle <= 8'h00;
            end else if (ref_idle != `FSKDM_REFLOST_CYC) begin
                ref_idle <= ref_idle + 8'h01;
                ref_lost_ev <= (ref_idle + 8'h01) == `FSKDM_REFLOST_CYC;
            end
        end
    end

    // Receive path controls; the receive band is independent of transmit rate
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_ctl <= '0;
            rx_data <= 1'b1;
        end else begin
            rx_ctl.band <= {mode.band_hi, mode.band_lo};
            rx_ctl.eq_en <= mode.eq_en && mode.band_hi && mode.band_lo;
            rx_ctl.demod_en <= mode.tx_en && mode.band_hi && !zero_power;
            rx_data <= (mode.tx_en && mode.band_hi) ? rx_demod_bit : 1'b1;
        end
    end

    // Detector input with amplitude hysteresis, or the 2100 Hz qualifier
    always_comb begin
        if (tones.det_2100 && mode.band_hi && mode.band_lo) begin
            det_in = tone_2100_valid && (rx_level >= on_thr);
        end else if (det_state == FSKDM_ACTIVE || det_state == FSKDM_QUAL_OFF) begin
            det_in = rx_level >= off_thr;
        end else begin
            det_in = rx_level >= on_thr;
        end
    end

    // Time hysteresis: level must persist before the flag sets or, outside zero power, clears
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            det_state <= FSKDM_IDLE;
            det_cnt <= '0;
            det_flag <= 1'b0;
            det_rise_ev <= 1'b0;
        end else begin
            det_rise_ev <= 1'b0;
            case (det_state)
                FSKDM_IDLE: begin
                    det_cnt <= '0;
                    if (det_in && !zero_power) begin
                        det_state <= FSKDM_QUAL_ON;
                    end
                end
                FSKDM_QUAL_ON: begin
                    det_cnt <= det_cnt + 1'b1;
                    if (!det_in || zero_power) begin
                        det_state <= FSKDM_IDLE;
                    end else if (det_cnt == ON_LAST) begin
                        det_state <= FSKDM_ACTIVE;
                        det_flag <= 1'b1;
                        det_rise_ev <= 1'b1;
                    end
                end
                FSKDM_ACTIVE: begin
                    det_cnt <= '0;
                    if (!det_in || zero_power) begin
                        det_state <= FSKDM_QUAL_OFF;
                    end
                end
                FSKDM_QUAL_OFF: begin
                    det_cnt <= det_cnt + 1'b1;
                    if (det_in && !zero_power) begin
                        det_state <= FSKDM_ACTIVE;
                    end else if (det_cnt == OFF_LAST || zero_power) begin
                        det_state <= FSKDM_IDLE;
                        det_flag <= 1'b0;
                    end
                end
                default: det_state <= FSKDM_IDLE;
            endcase
        end
    end

    // Tone selection
    always_comb begin
        tx_dual = 1'b0;
        inc[1] = '0;
        if (tones.dtmf) begin
            if (tones.single) begin
                inc[0] = tx_code[3] ? dtmf_low(tx_code) : dtmf_high(tx_code);
            end else begin
                inc[0] = dtmf_low(tx_code);
                inc[1] = dtmf_high(tx_code);
                tx_dual = 1'b1;
            end
        end else begin
            inc[0] = fsk_inc(bell, mode.rate_1200, tx_bit && mode.tx_en);
        end
    end

    assign tx_on = !zero_power && (tones.dtmf || mode.tx_en);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_tone
            fskdm_nco #(.ACC_W(ACC_W)) u_nco (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .step(ref_tick),
                .inc(inc[g]),
                .phase(phase[g])
            );
            assign tri_w[g] = phase[g][ACC_W-1] ? ~phase[g][ACC_W-2 -: 9] :
                              phase[g][ACC_W-2 -: 9];
        end
    endgenerate

    always_comb begin
        if (tx_dual) begin
            next_mod = 10'({1'b0, tri_w[0][8:1]}) + 10'({1'b0, tri_w[1][8:1]}) + `FSKDM_LIFT;
        end else begin
            next_mod = 10'(tri_w[0]) + `FSKDM_LIFT;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mod_out <= `FSKDM_MID;
            tx_filter_connect <= 1'b0;
        end else begin
            tx_filter_connect <= tones.dtmf ? tones.out_en : 1'b1;
            if (!tx_on) begin
                mod_out <= `FSKDM_MID;
            end else if (ref_tick) begin
                mod_out <= next_mod;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_osc_zero_power: assert property (zero_power |=> !osc_enable)
        else $error("oscillator left running in zero power");
    a_band_follows: assert property (##1 rx_ctl.band == $past({mode.band_hi, mode.band_lo}))
        else $error("receive band does not follow config");
    a_eq_only_1200: assert property (rx_ctl.eq_en |-> rx_ctl.band == 2'b11)
        else $error("equaliser on outside 1200 band");
    a_demod_gate: assert property (rx_ctl.demod_en |-> $past(mode.tx_en && mode.band_hi))
        else $error("demodulator enabled without bits 1 and 5");
    a_det_flag_set: assert property (det_rise_ev |=> status[`FSKDM_ST_DETECT])
        else $error("detect event did not set flag bit 4");
    a_det_qualify: assert property ($rose(det_flag) |-> $past(det_state) == FSKDM_QUAL_ON
        && $past(det_cnt) == ON_LAST)
        else $error("detect flag rose without full on time");
    a_mod_mid: assert property (!tones.dtmf && !mode.tx_en |=> mod_out == `FSKDM_MID)
        else $error("modulator not held at mid supply");
    a_filter_conn: assert property (tones.dtmf ##1 tones.dtmf |-> tx_filter_connect
        == $past(tones.out_en))
        else $error("tone output connect does not follow bit 6");
    a_tick_only: assert property (!ref_tick |=> $stable(phase[0]))
        else $error("tone phase advanced without reference edge");
    a_pair_low: assert property (tones.dtmf && !tones.single && tx_code == 4'h1
        |-> inc[0] == `FSKDM_INC(`FSKDM_F_697))
        else $error("keypad 1 low tone wrong");

    c_dtmf_pair: cover property (tones.dtmf && !tones.single && ref_tick);
    c_det_rise: cover property ($rose(det_flag));
    c_fsk_1200: cover property (!tones.dtmf && mode.tx_en && mode.rate_1200 && ref_tick);
    c_zero_power: cover property ($rose(zero_power));
endmodule

// ==== tb_fskdm_mode_control.sv ====
`timescale 1ns/1ps
`include "fskdm_defines.svh"
module tb_fskdm_mode_control;
    import fskdm_pkg::*;
    localparam int DON = 20;
    localparam int DOFF = 10;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ref_clk;
    logic [7:0] rx_level = 8'h00;
    logic tone_2100_valid = 1'b0;
    logic rx_demod_bit = 1'b1;
    logic tx_bit = 1'b1;
    logic osc_enable;
    fskdm_rxctl_type rx_ctl;
    logic rx_data;
    logic det_flag;
    logic tx_filter_connect;
    logic irq;
    logic [9:0] mod_out;
    logic [31:0] rd;
    logic err;
    int n;
    int n_mismatch = 0;
    int num_checks = 0;

    always #50 clk_sys = ~clk_sys;

    fskdm_top #(.DET_ON_CYCLES(DON), .DET_OFF_CYCLES(DOFF)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_clk(ref_clk), .rx_level(rx_level),
        .tone_2100_valid(tone_2100_valid), .rx_demod_bit(rx_demod_bit), .tx_bit(tx_bit),
        .osc_enable(osc_enable), .rx_ctl(rx_ctl), .rx_data(rx_data), .det_flag(det_flag),
        .mod_out(mod_out), .tx_filter_connect(tx_filter_connect), .irq(irq)
    );

    fskdm_ref_model partner (.run(osc_enable), .ref_clk(ref_clk));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    task cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task count_changes(output int ch);
        logic [9:0] last;
        ch = 0;
        last = mod_out;
        repeat (2000) begin
            @(posedge clk_sys);
            if (mod_out !== last) ch++;
            last = mod_out;
        end
    endtask

    // 2000 cycles hold 250 reference edges; the triangle takes 2^10 steps per turn
    function automatic bit in_band(input int ch, input int f);
        int e;
        e = int'(64'(f) * 64'd256000 / `FSKDM_REF_HZ);
        return ch >= e - 3 && ch <= e + 2;
    endfunction

    task wait_flag(input logic v);
        n = 0;
        while (det_flag !== v && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
    endtask

    task t_regs;
        apb(1'b0, `FSKDM_OFS_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        chk(osc_enable, 1'b0);
        chk(mod_out, 10'h200);
        apb(1'b0, `FSKDM_OFS_THRESH, 32'h0000_0000);
        chk(rd, 32'h0000_3040);
        apb(1'b1, 8'h24, 32'h0000_00FF);
        chk(err, 1'b1);
        apb(1'b0, 8'h24, 32'h0000_0000);
        chk({err, rd}, {1'b1, 32'h0000_0000});
        apb(1'b1, `FSKDM_OFS_CTRL, 32'h0000_0000);
        cyc(3);
        chk(osc_enable, 1'b1);
    endtask

    task t_rxctl;
        logic [7:0] m;
        logic [7:0] tbl [10] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h70, 8'h60, 8'h22, 8'h32,
                                 8'h23, 8'h42};
        rx_demod_bit <= 1'b0;
        foreach (tbl[i]) begin
            m = tbl[i];
            apb(1'b1, `FSKDM_OFS_MODE, {24'h00_0000, m});
            cyc(2);
            chk(rx_ctl.band, m[5:4]);
            chk(rx_ctl.eq_en, m[6] & m[5] & m[4]);
            chk(rx_ctl.demod_en, m[1] & m[5]);
            chk(rx_data, !(m[1] & m[5]));
        end
    endtask

    task t_mod;
        int ch;
        apb(1'b1, `FSKDM_OFS_TONES, 32'h0000_0000);
        apb(1'b1, `FSKDM_OFS_MODE, 32'h0000_0001);
        cyc(2);
        count_changes(ch);
        chk(ch, 32'h0000_0000);
        chk(mod_out, 10'h200);
        apb(1'b1, `FSKDM_OFS_MODE, 32'h0000_0003);
        tx_bit <= 1'b0;
        count_changes(ch);
        chk(ch != 0, 1'b1);
        chk(in_band(ch, `FSKDM_F_2100), 1'b1);
        chk(tx_filter_connect, 1'b1);
        apb(1'b1, `FSKDM_OFS_SETUP, 32'h0000_0080);
        count_changes(ch);
        chk(ch != 0, 1'b1);
        chk(in_band(ch, `FSKDM_F_2200), 1'b1);
        tx_bit <= 1'b1;
        count_changes(ch);
        chk(in_band(ch, `FSKDM_F_1200), 1'b1);
        apb(1'b1, `FSKDM_OFS_MODE, 32'h0000_0002);
        count_changes(ch);
        chk(in_band(ch, `FSKDM_F_387), 1'b1);
        apb(1'b1, `FSKDM_OFS_MODE, 32'h0000_0000);
        apb(1'b1, `FSKDM_OFS_TONES, 32'h0000_0080);
        cyc(2);
        chk(tx_filter_connect, 1'b0);
        count_changes(ch);
        chk(ch != 0, 1'b1);
        apb(1'b1, `FSKDM_OFS_TONES, 32'h0000_00D0);
        cyc(2);
        chk(tx_filter_connect, 1'b1);
        count_changes(ch);
        chk(ch != 0, 1'b1);
        chk(in_band(ch, `FSKDM_F_1633), 1'b1);
        apb(1'b1, `FSKDM_OFS_TXCODE, 32'h0000_0008);
        count_changes(ch);
        chk(in_band(ch, `FSKDM_F_852), 1'b1);
        apb(1'b1, `FSKDM_OFS_CTRL, 32'h0000_0001);
        cyc(3);
        chk(osc_enable, 1'b0);
        count_changes(ch);
        chk({ch != 0, mod_out}, {1'b0, 10'h200});
        apb(1'b1, `FSKDM_OFS_CTRL, 32'h0000_0000);
        apb(1'b1, `FSKDM_OFS_TONES, 32'h0000_0000);
    endtask

    task t_det;
        apb(1'b1, `FSKDM_OFS_MODE, 32'h0000_0020);
        apb(1'b1, `FSKDM_OFS_STATUS, 32'h0000_0011);
        apb(1'b1, `FSKDM_OFS_MASK, 32'h0000_0010);
        rx_level <= 8'h50;
        wait_flag(1'b1);
        chk(n >= DON && n <= DON + 5, 1'b1);
        cyc(3);
        chk(irq, 1'b1);
        apb(1'b0, `FSKDM_OFS_STATUS, 32'h0000_0000);
        chk(rd & 32'h0000_0010, 32'h0000_0010);
        apb(1'b1, `FSKDM_OFS_MASK, 32'h0000_0000);
        cyc(3);
        chk(irq, 1'b0);
        apb(1'b1, `FSKDM_OFS_MASK, 32'h0000_0010);
        cyc(3);
        chk(irq, 1'b1);
        apb(1'b1, `FSKDM_OFS_STATUS, 32'h0000_0010);
        cyc(3);
        chk(irq, 1'b0);
        rx_level <= 8'h38;
        cyc(30);
        chk(det_flag, 1'b1);
        rx_level <= 8'h10;
        wait_flag(1'b0);
        chk(n >= DOFF && n <= DOFF + 5, 1'b1);
    endtask

    task t_2100;
        apb(1'b1, `FSKDM_OFS_TONES, 32'h0000_0001);
        apb(1'b1, `FSKDM_OFS_MODE, 32'h0000_0030);
        rx_level <= 8'h50;
        cyc(40);
        chk(det_flag, 1'b0);
        tone_2100_valid <= 1'b1;
        wait_flag(1'b1);
        chk(n <= DON + 5, 1'b1);
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs;
        t_rxctl;
        t_mod;
        t_det;
        t_2100;
        give_verdict;
    end

    initial begin
        #3_000_000;
        n_mismatch++;
        give_verdict;
    end
endmodule
